//--- src/ccm_core.v
// Purpose: Charge counter monitor core with I2C target register file
// Assumes: Comparator, ADC and strap levels come from outside this clock
// Notes: Analog converter is started here and its result latched after a timed wait
// How it works
// - Strap code picks peak source current 5..25mA in 5mA steps, then 50/75/100mA
// - Source turns on below 160mV drop flag, off at 110mV recovery flag
// - Oscillator ticks every 480ns (12 core cycles) only while source on; each tick counts once except one coinciding with a charge write
// - Prescaler zero uses full 46-bit counter; visible charge is its top 16 bits
// - Four-bit prescaler, default zero, each step shortens counter by one bit
// - Input voltage sampled during on pulse and while off; 12-bit, 3.5ms each
// - Voltage sequence runs once every 1024 source-on cycles
// - Output voltage sampled at source on and off, stored in own registers
// - Die temperature measured every 1024 on-cycles, kept in status upper byte
// - I2C target only at address 1100100; SDA driven only for ack and data
// - Sub-addresses 01h..08h; first and last write-only, second read/write
// - Charge read gives visible 16 bits; write changes only upper byte
// - Writing clear-interrupt bit releases interrupt; bit returns to zero itself
// - Shutdown plus conversion-start runs measurements; start bit self-clears after
// - Ready bit set after requested conversions, cleared once read over I2C
// - Charge threshold byte defaults all ones; alarm when visible top byte reaches it
// - Overflow bit set when shortened counter wraps past its maximum
// - Cold alarm at or below low byte, hot alarm at or above high byte
// - Strap code latched at start-up, reported in status bits 7..5
// - Reset loads control FF00h, temperature limits 00FFh, all else zero
// - Voltage registers hold 12-bit result low, top four bits read zero
// - Interrupt output goes low on charge, temperature or overflow alarm, stays low until cleared
// - Counter-check mode puts counter input clock on the interrupt output
// - Shutdown stops counting, disables current limit and bypasses input to output
// - Charge alarm checked on visible LSB change or control/charge writes
`timescale 1ns/1ns
`include "ccm_defines.vh"
module ccm_core #(
  parameter CONV_CYC = `CCM_CONV_CYC,
  parameter OSC_CYC = `CCM_OSC_CYC
) (
  input wire core_clk,
  input wire reset_n,
  input wire [2:0] current_limit_strap,
  input wire load_side_low,
  input wire load_side_recovered,
  input wire [11:0] adc_data,
  input wire scl_in,
  input wire sda_in,
  output wire sda_out,
  output reg sda_oe,
  output reg irq_n,
  output reg source_on,
  output reg bypass_on,
  output reg [6:0] peak_current_ma,
  output reg [4:0] adc_sample,
  output reg adc_busy,
  output reg [2:0] adc_channel
);
  // ----------------------------------------
  // State encodings and helpers
  // ----------------------------------------
  localparam ST_IDLE = 7'b000_0001;
  localparam ST_ADDR = 7'b000_0010;
  localparam ST_SUB = 7'b000_0100;
  localparam ST_WR = 7'b000_1000;
  localparam ST_RD = 7'b001_0000;
  localparam ST_ACK = 7'b010_0000;
  localparam ST_MACK = 7'b100_0000;
  localparam CH_INON = 0;
  localparam CH_INOFF = 1;
  localparam CH_OUTON = 2;
  localparam CH_OUTOFF = 3;
  localparam CH_TEMP = 4;

  function [6:0] strap_to_ma;
    input [2:0] code;
    begin
      case (code)
        3'h5: strap_to_ma = 7'd50;
        3'h6: strap_to_ma = 7'd75;
        3'h7: strap_to_ma = 7'd100;
        default: strap_to_ma = 7'd5 * ({4'h0, code} + 7'd1);
      endcase
    end
  endfunction

  function [2:0] first_pending;
    input [4:0] p;
    integer i;
    begin
      first_pending = 3'h0;
      for (i = 4; i >= 0; i = i - 1) begin
        if (p[i]) begin
          first_pending = i[2:0];
        end
      end
    end
  endfunction

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  reg [2:0] strap_s1_q, strap_s2_q;
  reg low_s1_q, low_s2_q, rec_s1_q, rec_s2_q;
  reg scl_s1_q, scl_s2_q, scl_s3_q, sda_s1_q, sda_s2_q, sda_s3_q;
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      low_s1_q <= 1'b0;
      low_s2_q <= 1'b0;
      rec_s1_q <= 1'b0;
      rec_s2_q <= 1'b0;
      scl_s1_q <= 1'b1;
      scl_s2_q <= 1'b1;
      scl_s3_q <= 1'b1;
      sda_s1_q <= 1'b1;
      sda_s2_q <= 1'b1;
      sda_s3_q <= 1'b1;
    end else begin
      low_s1_q <= load_side_low;
      low_s2_q <= low_s1_q;
      rec_s1_q <= load_side_recovered;
      rec_s2_q <= rec_s1_q;
      scl_s1_q <= scl_in;
      scl_s2_q <= scl_s1_q;
      scl_s3_q <= scl_s2_q;
      sda_s1_q <= sda_in;
      sda_s2_q <= sda_s1_q;
      sda_s3_q <= sda_s2_q;
    end
  end

  // Straps not reset so the chain holds the pin level at release
  always @(posedge core_clk) begin
    strap_s1_q <= current_limit_strap;
    strap_s2_q <= strap_s1_q;
  end

  // ----------------------------------------
  // Registers and shared wires
  // ----------------------------------------
  reg [15:0] ctrl_q, talm_q;
  reg [11:0] vin_on_q, vin_off_q, vout_on_q, vout_off_q;
  reg [7:0] temp_q;
  reg [4:0] stat_q;
  reg [2:0] strap_q;
  reg strap_done_q;
  reg [`CCM_CNT_W-1:0] cnt_q;
  reg [3:0] osc_q;
  reg osc_phase_q, vis0_q, irq_q, wr_eval_q, req_taken_q;
  reg [9:0] on_cnt_q;
  reg meas_q;
  reg [4:0] pend_q;
  reg [23:0] conv_q;
  reg wr_stb, rd_c_stb;
  reg [7:0] sub_q;
  reg [15:0] wdat_q;
  wire shdn = ctrl_q[`CCM_CTRL_SHDN];
  wire [3:0] presc = ctrl_q[3:0];
  wire [5:0] vshift = 6'd30 - {2'b00, presc};
  wire [5:0] bshift = 6'd38 - {2'b00, presc};
  wire [`CCM_CNT_W-1:0] len_mask = {`CCM_CNT_W{1'b1}} >> presc;
  wire [`CCM_CNT_W-1:0] vis_full = cnt_q >> vshift;
  wire [15:0] vis = vis_full[15:0];
  wire tick = source_on && !shdn && (osc_q == OSC_CYC[3:0] - 4'h1);
  wire wrap = tick && ((cnt_q & len_mask) == len_mask);
  wire src_rise, src_fall;
  reg src_d_q;
  assign src_rise = source_on & ~src_d_q;
  assign src_fall = ~source_on & src_d_q;
  wire conv_done = adc_busy && (conv_q == CONV_CYC[23:0] - 24'h1);
  wire wr_ctrl = wr_stb && (sub_q == `CCM_SUB_CTRL);
  wire wr_chrg = wr_stb && (sub_q == `CCM_SUB_CHRG);
  assign sda_out = 1'b0;

  // ----------------------------------------
  // Strap latch and source control
  // ----------------------------------------
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      strap_q <= 3'h0;
      strap_done_q <= 1'b0;
      peak_current_ma <= 7'd0;
      source_on <= 1'b0;
      src_d_q <= 1'b0;
      bypass_on <= 1'b0;
    end else begin
      if (!strap_done_q) begin
        strap_q <= strap_s2_q;
        strap_done_q <= 1'b1;
      end
      peak_current_ma <= shdn ? 7'd0 : strap_to_ma(strap_q);
      bypass_on <= shdn;
      if (shdn) begin
        source_on <= 1'b0;
      end else if (low_s2_q) begin
        source_on <= 1'b1;
      end else if (rec_s2_q) begin
        source_on <= 1'b0;
      end
      src_d_q <= source_on;
    end
  end

  // ----------------------------------------
  // Oscillator and charge counter
  // ----------------------------------------
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      osc_q <= 4'h0;
      osc_phase_q <= 1'b0;
      cnt_q <= {`CCM_CNT_W{1'b0}};
      vis0_q <= 1'b0;
    end else begin
      if (!source_on || shdn) begin
        osc_q <= 4'h0;
      end else if (tick) begin
        osc_q <= 4'h0;
        osc_phase_q <= ~osc_phase_q;
      end else begin
        osc_q <= osc_q + 4'h1;
      end
      if (wr_chrg) begin
        cnt_q <= (cnt_q & ~({{38{1'b0}}, 8'hFF} << bshift)) |
                 ({{38{1'b0}}, wdat_q[15:8]} << bshift);
      end else if (tick) begin
        cnt_q <= (cnt_q + {{45{1'b0}}, 1'b1}) & len_mask;
      end
      vis0_q <= vis[0];
    end
  end

  // ----------------------------------------
  // Measurement scheduling and converter
  // ----------------------------------------
  wire host_req = ctrl_q[`CCM_CTRL_CONV] && shdn && !req_taken_q;
  reg [4:0] pend_d;
  always @* begin
    pend_d = pend_q;
    if (conv_done) begin
      pend_d[adc_channel] = 1'b0;
    end
    if (src_rise && on_cnt_q == 10'h3FF && !shdn) begin
      pend_d[CH_INON] = 1'b1;
      pend_d[CH_OUTON] = 1'b1;
    end
    if (src_fall && meas_q) begin
      pend_d[CH_INOFF] = 1'b1;
      pend_d[CH_OUTOFF] = 1'b1;
      pend_d[CH_TEMP] = 1'b1;
    end
    if (host_req) begin
      pend_d[CH_INOFF] = 1'b1;
      pend_d[CH_TEMP] = 1'b1;
    end
  end

  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      on_cnt_q <= 10'h000;
      meas_q <= 1'b0;
      pend_q <= 5'h00;
      adc_sample <= 5'h00;
      adc_busy <= 1'b0;
      adc_channel <= 3'h0;
      conv_q <= 24'h00_0000;
      req_taken_q <= 1'b0;
    end else begin
      pend_q <= pend_d;
      adc_sample <= pend_d & ~pend_q;
      if (src_rise) begin
        on_cnt_q <= on_cnt_q + 10'h001;
      end
      if (src_rise && on_cnt_q == 10'h3FF && !shdn) begin
        meas_q <= 1'b1;
      end else if (src_fall) begin
        meas_q <= 1'b0;
      end
      if (host_req) begin
        req_taken_q <= 1'b1;
      end else if (req_taken_q && pend_q == 5'h00 && !adc_busy) begin
        req_taken_q <= 1'b0;
      end
      if (conv_done) begin
        adc_busy <= 1'b0;
        conv_q <= 24'h00_0000;
      end else if (adc_busy) begin
        conv_q <= conv_q + 24'h00_0001;
      end else if (pend_q != 5'h00) begin
        adc_busy <= 1'b1;
        adc_channel <= first_pending(pend_q);
      end
    end
  end

  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      vin_on_q <= 12'h000;
      vin_off_q <= 12'h000;
      vout_on_q <= 12'h000;
      vout_off_q <= 12'h000;
      temp_q <= 8'h00;
    end else if (conv_done) begin
      case (adc_channel)
        CH_INON: vin_on_q <= adc_data;
        CH_INOFF: vin_off_q <= adc_data;
        CH_OUTON: vout_on_q <= adc_data;
        CH_OUTOFF: vout_off_q <= adc_data;
        default: temp_q <= adc_data[11:4];
      endcase
    end
  end

  // ----------------------------------------
  // Control, status and alarms
  // ----------------------------------------
  wire temp_eval = conv_done && adc_channel == CH_TEMP;
  wire cold_now = adc_data[11:4] <= talm_q[7:0];
  wire hot_now = adc_data[11:4] >= talm_q[15:8];
  wire chg_eval = (vis[0] != vis0_q) || wr_eval_q;
  wire chg_now = vis[15:8] >= ctrl_q[15:8];
  wire alarm_set = wrap || (chg_eval && chg_now) || (temp_eval && (cold_now || hot_now));
  wire req_fin = req_taken_q && pend_q == 5'h00 && !adc_busy;
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_q <= `CCM_CTRL_RST;
      talm_q <= `CCM_TALM_RST;
      stat_q <= 5'h00;
      irq_q <= 1'b0;
      irq_n <= 1'b1;
      wr_eval_q <= 1'b0;
    end else begin
      wr_eval_q <= wr_ctrl || wr_chrg;
      if (wr_ctrl) begin
        ctrl_q <= wdat_q;
      end else begin
        if (ctrl_q[`CCM_CTRL_CLRINT]) begin
          ctrl_q[`CCM_CTRL_CLRINT] <= 1'b0;
        end
        if (req_fin) begin
          ctrl_q[`CCM_CTRL_CONV] <= 1'b0;
        end
      end
      if (wr_stb && sub_q == `CCM_SUB_TALM) begin
        talm_q <= wdat_q;
      end
      if (wrap) begin
        stat_q[`CCM_STAT_OVF] <= 1'b1;
      end else if (ctrl_q[`CCM_CTRL_CLRINT]) begin
        stat_q[`CCM_STAT_OVF] <= 1'b0;
      end
      if (chg_eval) begin
        stat_q[`CCM_STAT_CALM] <= chg_now;
      end
      if (temp_eval) begin
        stat_q[`CCM_STAT_COLD] <= cold_now;
        stat_q[`CCM_STAT_HOT] <= hot_now;
      end
      if (req_fin) begin
        stat_q[`CCM_STAT_RDY] <= 1'b1;
      end else if (rd_c_stb) begin
        stat_q[`CCM_STAT_RDY] <= 1'b0;
      end
      // New alarm beats a simultaneous clear
      if (alarm_set) begin
        irq_q <= 1'b1;
      end else if (ctrl_q[`CCM_CTRL_CLRINT]) begin
        irq_q <= 1'b0;
      end
      irq_n <= ctrl_q[`CCM_CTRL_CHECK] ? osc_phase_q : ~irq_q;
    end
  end

  // ----------------------------------------
  // I2C target
  // ----------------------------------------
  wire scl_rise = scl_s2_q & ~scl_s3_q;
  wire scl_fall = ~scl_s2_q & scl_s3_q;
  wire i2c_start = scl_s2_q & scl_s3_q & sda_s3_q & ~sda_s2_q;
  wire i2c_stop = scl_s2_q & scl_s3_q & ~sda_s3_q & sda_s2_q;
  reg [6:0] st_q, nxt_q;
  reg [3:0] bit_q;
  reg [7:0] sh_q;
  reg [15:0] tx_q;
  reg hi_q, mack_q;
  reg [15:0] rd_val;
  always @* begin
    case (sub_q)
      `CCM_SUB_CHRG: rd_val = vis;
      `CCM_SUB_STAT: rd_val = {temp_q, strap_q, stat_q};
      `CCM_SUB_VINON: rd_val = {4'h0, vin_on_q};
      `CCM_SUB_VINOFF: rd_val = {4'h0, vin_off_q};
      `CCM_SUB_VOUTON: rd_val = {4'h0, vout_on_q};
      `CCM_SUB_VOUTOFF: rd_val = {4'h0, vout_off_q};
      default: rd_val = `CCM_ZERO_RST;
    endcase
  end

  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_q <= ST_IDLE;
      nxt_q <= ST_IDLE;
      bit_q <= 4'h0;
      sh_q <= 8'h00;
      tx_q <= 16'h0000;
      hi_q <= 1'b0;
      mack_q <= 1'b0;
      sub_q <= 8'h00;
      wdat_q <= 16'h0000;
      sda_oe <= 1'b0;
      wr_stb <= 1'b0;
      rd_c_stb <= 1'b0;
    end else begin
      wr_stb <= 1'b0;
      rd_c_stb <= 1'b0;
      if (i2c_start) begin
        st_q <= ST_ADDR;
        bit_q <= 4'h0;
        sda_oe <= 1'b0;
      end else if (i2c_stop) begin
        st_q <= ST_IDLE;
        sda_oe <= 1'b0;
      end else if (scl_rise) begin
        if (st_q == ST_ADDR || st_q == ST_SUB || st_q == ST_WR) begin
          sh_q <= {sh_q[6:0], sda_s2_q};
          bit_q <= bit_q + 4'h1;
        end
        if (st_q == ST_MACK) begin
          mack_q <= ~sda_s2_q;
        end
      end else if (scl_fall) begin
        case (st_q)
          ST_ADDR, ST_SUB, ST_WR: begin
            if (bit_q == 4'h8) begin
              bit_q <= 4'h0;
              sda_oe <= 1'b1;
              st_q <= ST_ACK;
              if (st_q == ST_ADDR) begin
                if (sh_q[7:1] != `CCM_I2C_ADDR) begin
                  sda_oe <= 1'b0;
                  st_q <= ST_IDLE;
                end else if (sh_q[0]) begin
                  nxt_q <= ST_RD;
                  tx_q <= rd_val;
                  rd_c_stb <= (sub_q == `CCM_SUB_STAT);
                end else begin
                  nxt_q <= ST_SUB;
                end
              end else if (st_q == ST_SUB) begin
                sub_q <= sh_q;
                hi_q <= 1'b0;
                nxt_q <= ST_WR;
              end else begin
                nxt_q <= ST_WR;
                hi_q <= ~hi_q;
                if (!hi_q) begin
                  wdat_q[15:8] <= sh_q;
                end else begin
                  wdat_q[7:0] <= sh_q;
                  wr_stb <= 1'b1;
                end
              end
            end
          end
          ST_ACK: begin
            st_q <= nxt_q;
            sda_oe <= (nxt_q == ST_RD) ? ~tx_q[15] : 1'b0;
          end
          ST_RD: begin
            tx_q <= {tx_q[14:0], 1'b0};
            bit_q <= bit_q + 4'h1;
            if (bit_q == 4'h7) begin
              sda_oe <= 1'b0;
              st_q <= ST_MACK;
            end else begin
              sda_oe <= ~tx_q[14];
            end
          end
          ST_MACK: begin
            bit_q <= 4'h0;
            st_q <= mack_q ? ST_RD : ST_IDLE;
            sda_oe <= mack_q ? ~tx_q[15] : 1'b0;
          end
          default: st_q <= st_q;
        endcase
      end
    end
  end
endmodule

//--- src/ccm_defines.vh
// Purpose: Shared constants of the charge counter monitor core
// Assumes: 25 MHz core clock
// Notes: Times kept in their own units, cycle counts derived
`ifndef CCM_DEFINES_VH
`define CCM_DEFINES_VH
// ----------------------------------------
// Register sub-addresses
// ----------------------------------------
`define CCM_SUB_CTRL 8'h01
`define CCM_SUB_CHRG 8'h02
`define CCM_SUB_STAT 8'h03
`define CCM_SUB_VINON 8'h04
`define CCM_SUB_VINOFF 8'h05
`define CCM_SUB_VOUTON 8'h06
`define CCM_SUB_VOUTOFF 8'h07
`define CCM_SUB_TALM 8'h08
// ----------------------------------------
// Reset values and bus address
// ----------------------------------------
`define CCM_CTRL_RST 16'hFF00
`define CCM_TALM_RST 16'h00FF
`define CCM_ZERO_RST 16'h0000
`define CCM_I2C_ADDR 7'h64
// ----------------------------------------
// Control and status field positions
// ----------------------------------------
`define CCM_CTRL_CLRINT 4
`define CCM_CTRL_CHECK 5
`define CCM_CTRL_SHDN 6
`define CCM_CTRL_CONV 7
`define CCM_STAT_OVF 0
`define CCM_STAT_CALM 1
`define CCM_STAT_COLD 2
`define CCM_STAT_HOT 3
`define CCM_STAT_RDY 4
// ----------------------------------------
// Timing and sizes
// ----------------------------------------
`define CCM_CLK_NS 40
`define CCM_OSC_NS 500
`define CCM_OSC_CYC (`CCM_OSC_NS / `CCM_CLK_NS)
`define CCM_CONV_US 3500
`define CCM_CONV_CYC ((`CCM_CONV_US * 1000) / `CCM_CLK_NS)
`define CCM_MEAS_EVERY 1024
`define CCM_CNT_W 46
`endif

//--- verif/ccm_core_props.sv
// Purpose: Port-level properties of the charge counter monitor core
// Assumes: Single core clock, asynchronous active-low reset
// Notes: Converter length follows the bound CONV_CYC parameter
`timescale 1ns/1ns
module ccm_core_props #(
  parameter CONV_CYC = 87500
) (
  input wire core_clk,
  input wire reset_n,
  input wire load_side_low,
  input wire load_side_recovered,
  input wire scl_in,
  input wire sda_out,
  input wire sda_oe,
  input wire source_on,
  input wire bypass_on,
  input wire [6:0] peak_current_ma,
  input wire [4:0] adc_sample,
  input wire adc_busy,
  input wire [2:0] adc_channel
);
  reg [1:0] rst_q;
  reg [2:0] ch_q;
  integer bcnt_q;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);
  // ----------------------------------------
  // Helper counters
  // ----------------------------------------
  // Per-channel busy length, restarted on a channel change
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_q <= 2'h0;
      ch_q <= 3'h0;
      bcnt_q <= 0;
    end else begin
      if (rst_q != 2'h3)
        rst_q <= rst_q + 2'h1;
      ch_q <= adc_channel;
      if (!adc_busy)
        bcnt_q <= 0;
      else if (adc_channel != ch_q)
        bcnt_q <= 1;
      else
        bcnt_q <= bcnt_q + 1;
    end
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  property p_sda_low;
    sda_out == 1'b0;
  endproperty
  a_sda_low: assert property (p_sda_low) else $error("sda data value not low");
  // Moving SDA under a high SCL would fake a START or STOP
  property p_sda_scl;
    $changed(sda_oe) |-> !scl_in;
  endproperty
  a_sda_scl: assert property (p_sda_scl) else $error("sda moved while scl high");
  property p_bypass;
    bypass_on |-> !source_on && peak_current_ma == 7'h00;
  endproperty
  a_bypass: assert property (p_bypass) else $error("source active in bypass");
  property p_peak;
    rst_q == 2'h3 && !bypass_on |->
      peak_current_ma inside {7'h05, 7'h0A, 7'h0F, 7'h14, 7'h19, 7'h32, 7'h4B, 7'h64};
  endproperty
  a_peak: assert property (p_peak) else $error("peak current not a strap value");
  property p_src_on;
    $rose(source_on) |-> $past(load_side_low, 2) || $past(load_side_low, 3) || $past(load_side_low, 4);
  endproperty
  a_src_on: assert property (p_src_on) else $error("source on without low flag");
  property p_src_off;
    $fell(source_on) && !bypass_on |->
      $past(load_side_recovered, 2) || $past(load_side_recovered, 3) || $past(load_side_recovered, 4);
  endproperty
  a_src_off: assert property (p_src_off) else $error("source off without recovery");
  property p_in_on;
    adc_sample[0] |-> source_on && adc_sample[1] == 1'b0;
  endproperty
  a_in_on: assert property (p_in_on) else $error("on sample outside source pulse");
  property p_busy_run;
    adc_busy && adc_channel == ch_q |-> bcnt_q < CONV_CYC;
  endproperty
  a_busy_run: assert property (p_busy_run) else $error("conversion too long");
  property p_busy_end;
    bcnt_q != 0 && (!adc_busy || adc_channel != ch_q) |-> bcnt_q == CONV_CYC;
  endproperty
  a_busy_end: assert property (p_busy_end) else $error("conversion length wrong");
endmodule

bind ccm_core ccm_core_props #(.CONV_CYC(CONV_CYC)) u_props (
  .core_clk(core_clk), .reset_n(reset_n), .load_side_low(load_side_low),
  .load_side_recovered(load_side_recovered), .scl_in(scl_in), .sda_out(sda_out), .sda_oe(sda_oe),
  .source_on(source_on), .bypass_on(bypass_on), .peak_current_ma(peak_current_ma),
  .adc_sample(adc_sample), .adc_busy(adc_busy), .adc_channel(adc_channel));

//--- verif/ccm_i2c_host.sv
// Purpose: Behavioural I2C host for the monitor core
// Assumes: Open-drain SDA with pull-up resolved by the bench
// Notes: Each SCL phase lasts 10 core cycles, well over the minimum
`timescale 1ns/1ns
module ccm_i2c_host (
  input wire core_clk,
  input wire sda_line,
  output reg scl_drv,
  output reg sda_low
);
  initial begin
    scl_drv = 1'b1;
    sda_low = 1'b0;
  end
  task wt(input integer n);
    begin
      repeat (n) @(posedge core_clk);
      #2;
    end
  endtask
  // ----------------------------------------
  // Bus conditions
  // ----------------------------------------
  // Only the host drives SCL; SDA moves while SCL low
  task xbit(input reg b, output reg r);
    begin
      wt(5);
      sda_low = ~b;
      wt(5);
      scl_drv = 1'b1;
      wt(5);
      r = sda_line;
      wt(5);
      scl_drv = 1'b0;
    end
  endtask
  task xbyte(input [7:0] d, input reg mack, output reg [7:0] q, output reg ack);
    integer i;
    reg r;
    begin
      for (i = 7; i >= 0; i = i - 1) begin
        xbit(d[i], r);
        q[i] = r;
      end
      xbit(~mack, r);
      ack = ~r;
    end
  endtask
  task start;
    begin
      sda_low = 1'b0;
      wt(8);
      scl_drv = 1'b1;
      wt(5);
      sda_low = 1'b1;
      wt(5);
      scl_drv = 1'b0;
    end
  endtask
  task stop;
    begin
      wt(5);
      sda_low = 1'b1;
      wt(5);
      scl_drv = 1'b1;
      wt(5);
      sda_low = 1'b0;
      wt(10);
    end
  endtask
  // ----------------------------------------
  // Register transfers
  // ----------------------------------------
  task write_reg(input [6:0] adr, input [7:0] sub, input [15:0] v, output reg ok);
    reg [7:0] q;
    reg a;
    begin
      start;
      xbyte({adr, 1'b0}, 1'b0, q, ok);
      if (ok) begin
        xbyte(sub, 1'b0, q, a);
        ok = ok & a;
        xbyte(v[15:8], 1'b0, q, a);
        ok = ok & a;
        xbyte(v[7:0], 1'b0, q, a);
        ok = ok & a;
      end
      stop;
    end
  endtask
  task read_reg(input [7:0] sub, output [15:0] v);
    reg [7:0] q;
    reg a;
    begin
      start;
      xbyte(8'hC8, 1'b0, q, a);
      xbyte(sub, 1'b0, q, a);
      start;
      xbyte(8'hC9, 1'b0, q, a);
      xbyte(8'hFF, 1'b1, v[15:8], a);
      xbyte(8'hFF, 1'b0, v[7:0], a);
      stop;
    end
  endtask
endmodule

//--- verif/testbench.sv
// Purpose: Self-checking bench for the charge counter monitor core
// Assumes: Short conversion time of 20 cycles for run length
// Notes: Converter data encodes the channel so each register is distinct
`timescale 1ns/1ns
module testbench;
  reg core_clk;
  reg reset_n;
  reg [2:0] strap;
  reg lo;
  reg rec;
  reg src_q;
  wire scl;
  wire host_low;
  wire sda_out;
  wire sda_oe;
  wire irq_n;
  wire source_on;
  wire bypass_on;
  wire [6:0] peak_ma;
  wire [4:0] adc_sample;
  wire adc_busy;
  wire [2:0] adc_channel;
  wire sda_line = ~(sda_oe | host_low);
  wire [11:0] adc_data = {1'b0, adc_channel, 8'h5A};
  integer error_cnt;
  integer n_checks;
  integer n_rise;
  integer n_samp;
  ccm_core #(.CONV_CYC(20)) DUT (
    .core_clk(core_clk), .reset_n(reset_n), .current_limit_strap(strap), .load_side_low(lo),
    .load_side_recovered(rec), .adc_data(adc_data), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out),
    .sda_oe(sda_oe), .irq_n(irq_n), .source_on(source_on), .bypass_on(bypass_on), .peak_current_ma(peak_ma),
    .adc_sample(adc_sample), .adc_busy(adc_busy), .adc_channel(adc_channel));
  ccm_i2c_host u_host (.core_clk(core_clk), .sda_line(sda_line), .scl_drv(scl), .sda_low(host_low));
  always #20 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    src_q <= source_on;
    if (source_on === 1'b1 && src_q === 1'b0)
      n_rise <= n_rise + 1;
    if (adc_sample[0] === 1'b1)
      n_samp <= n_samp + 1;
  end
  // ----------------------------------------
  // Bench tasks
  // ----------------------------------------
  task chk(input [15:0] seen, input [15:0] exp);
    begin
      n_checks = n_checks + 1;
      if (seen !== exp) begin
        error_cnt = error_cnt + 1;
        $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  task conclude;
    begin
      if (error_cnt == 0 && n_checks > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask
  task cyc(input integer n);
    begin
      repeat (n) @(posedge core_clk);
      #2;
    end
  endtask
  task rd(input [7:0] sub, input [15:0] exp);
    reg [15:0] v;
    begin
      u_host.read_reg(sub, v);
      chk(v, exp);
    end
  endtask
  task wr(input [7:0] sub, input [15:0] v);
    reg ok;
    begin
      u_host.write_reg(7'h64, sub, v, ok);
      chk({15'h0000, ok}, 16'h0001);
    end
  endtask
  // Each pulse gives the synchronisers several cycles per level
  task pulse;
    begin
      lo = 1'b1;
      rec = 1'b0;
      cyc(5);
      lo = 1'b0;
      rec = 1'b1;
      cyc(5);
    end
  endtask
  task wait_conv;
    integer i;
    integer k;
    begin
      k = 0;
      for (i = 0; i < 500 && k < 8; i = i + 1) begin
        @(posedge core_clk);
        k = adc_busy === 1'b0 ? k + 1 : 0;
      end
      if (k < 8) begin
        error_cnt = error_cnt + 1;
        conclude;
      end
      #2;
    end
  endtask
  task toggles(input integer n, output integer t);
    integer i;
    reg p;
    begin
      t = 0;
      p = irq_n;
      for (i = 0; i < n; i = i + 1) begin
        @(posedge core_clk);
        if (irq_n !== p)
          t = t + 1;
        p = irq_n;
      end
      #2;
    end
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin : main
    integer i;
    integer t;
    reg ok;
    core_clk = 1'b0;
    reset_n = 1'b0;
    strap = 3'h5;
    lo = 1'b0;
    rec = 1'b0;
    src_q = 1'b0;
    error_cnt = 0;
    n_checks = 0;
    n_rise = 0;
    n_samp = 0;
    cyc(12);
    reset_n = 1'b1;
    cyc(4);
    chk({9'h000, peak_ma}, 16'h0032);
    chk({15'h0000, irq_n}, 16'h0001);
    for (i = 0; i < 10; i = i + 1)
      rd(i[7:0], (i == 3) ? 16'h00A0 : 16'h0000);
    for (i = 0; i < 8; i = i + 1) begin
      strap = i[2:0];
      reset_n = 1'b0;
      cyc(3);
      reset_n = 1'b1;
      cyc(4);
      chk({9'h000, peak_ma}, (i < 5) ? 16'h0005 * (i + 1) : 16'h0019 * (i - 3));
    end
    strap = 3'h2;
    rd(8'h03, 16'h00E0);
    u_host.write_reg(7'h65, 8'h02, 16'h5500, ok);
    chk({15'h0000, ok}, 16'h0000);
    rd(8'h02, 16'h0000);
    wr(8'h02, 16'hAB12);
    rd(8'h02, 16'hAB00);
    wr(8'h01, 16'hFF08);
    wr(8'h02, 16'hCD00);
    wr(8'h01, 16'hFF00);
    rd(8'h02, 16'hABCD);
    wr(8'h03, 16'hFFFF);
    rd(8'h03, 16'h00E0);
    wr(8'h01, 16'hAC00);
    cyc(4);
    chk({15'h0000, irq_n}, 16'h0001);
    wr(8'h01, 16'hAB00);
    cyc(4);
    chk({15'h0000, irq_n}, 16'h0000);
    rd(8'h03, 16'h00E2);
    wr(8'h01, 16'hFF10);
    cyc(4);
    chk({15'h0000, irq_n}, 16'h0001);
    rd(8'h03, 16'h00E0);
    wr(8'h01, 16'hFF20);
    lo = 1'b1;
    cyc(10);
    toggles(120, t);
    chk({15'h0000, t >= 9 && t <= 11}, 16'h0001);
    lo = 1'b0;
    rec = 1'b1;
    cyc(10);
    toggles(60, t);
    chk(t[15:0], 16'h0000);
    wr(8'h08, 16'h4000);
    wr(8'h01, 16'hFFC0);
    lo = 1'b1;
    rec = 1'b0;
    cyc(10);
    chk({7'h00, source_on, bypass_on, peak_ma}, 16'h0080);
    wait_conv;
    rd(8'h03, 16'h45F8);
    chk({15'h0000, irq_n}, 16'h0000);
    rd(8'h05, 16'h015A);
    rd(8'h04, 16'h0000);
    rd(8'h03, 16'h45E8);
    lo = 1'b0;
    wr(8'h01, 16'hFF10);
    for (i = 0; i < 1100 && n_rise < 1023; i = i + 1)
      pulse;
    chk(n_rise[15:0], 16'h03FF);
    chk(n_samp[15:0], 16'h0000);
    pulse;
    chk(n_samp[15:0], 16'h0001);
    wait_conv;
    rd(8'h04, 16'h005A);
    rd(8'h06, 16'h025A);
    rd(8'h07, 16'h035A);
    conclude;
  end
endmodule
